// ### rtl/cprs_map.svh
// constants of the clock, pll and reset sequencer
`ifndef CPRS_MAP_SVH
`define CPRS_MAP_SVH

// clock runs on the reference: 100 ns
`define CPRS_CLK_NS          100
`define CPRS_TREF_NS         100

// times below are counted in reference periods
`define CPRS_PLL_LOCK_TREF   131072
`define CPRS_WD_PULSE_TREF   512
`define CPRS_BUS_DELAY_TREF  32

`define CPRS_PLL_LOCK_CYC    (`CPRS_PLL_LOCK_TREF * `CPRS_TREF_NS / `CPRS_CLK_NS)
`define CPRS_WD_PULSE_CYC    (`CPRS_WD_PULSE_TREF * `CPRS_TREF_NS / `CPRS_CLK_NS)
`define CPRS_BUS_DELAY_CYC   (`CPRS_BUS_DELAY_TREF * `CPRS_TREF_NS / `CPRS_CLK_NS)

// field widths and reset values
`define CPRS_RATIO_W         4
`define CPRS_RATIO_RST       4'h0
`define CPRS_DIV_W           2
`define CPRS_DIV_RST         2'h0
`define CPRS_LOCK_CNT_W      17
`define CPRS_WD_CNT_W        9
`define CPRS_BUS_CNT_W       5

`endif

// ### rtl/cprs_pkg.sv
// types of the clock, pll and reset sequencer
`include "cprs_map.svh"

package cprs_pkg;

    typedef enum logic [1:0] {
        CPRS_SEQ_HOLD,
        CPRS_SEQ_WAIT,
        CPRS_SEQ_RUN
    } cprs_seq_e;

    // core clock configuration; rate_k is the core rate in units of reference/2
    typedef struct packed {
        logic                       half_rate;
        logic                       locking;
        logic [`CPRS_RATIO_W-1:0]   ratio;
        logic [`CPRS_RATIO_W-1:0]   rate_k;
    } cprs_core_cfg_s;

endpackage : cprs_pkg

// ### rtl/cprs_clkout_div.sv
// divider of the core clock onto the clock output pin
`timescale 1ns/1ps
`default_nettype none
`include "cprs_map.svh"

module cprs_clkout_div (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       hold,
    input  wire logic                       div_wr,
    input  wire logic [`CPRS_DIV_W-1:0]     div_wdata,
    input  wire logic [`CPRS_RATIO_W-1:0]   rate_k,
    output var  logic                       clock_out_pin
);

    logic [`CPRS_DIV_W-1:0] clock_pin_divider_r;
    logic [2:0]             core_div;
    logic [2:0]             half_per;
    logic [2:0]             phase_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clock_pin_divider_r <= `CPRS_DIV_RST;
        end else if (hold) begin
            clock_pin_divider_r <= `CPRS_DIV_RST;
        end else if (div_wr) begin
            clock_pin_divider_r <= div_wdata;
        end
    end

    // 0: core/4, 1: core/2, otherwise core/1
    always_comb begin
        core_div = 3'h1;
        case (clock_pin_divider_r)
            2'h0:    core_div = 3'h4;
            2'h1:    core_div = 3'h2;
            default: core_div = 3'h1;
        endcase
    end

    // half period in reference cycles; faster than reference/2 saturates
    always_comb begin
        half_per = 3'h1;
        if (rate_k != 4'h0) begin
            half_per = 3'((4'(core_div)) / rate_k);
        end
        if (half_per == 3'h0) begin
            half_per = 3'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_r       <= 3'h0;
            clock_out_pin <= 1'b0;
        end else if (hold) begin
            phase_r       <= 3'h0;
            clock_out_pin <= 1'b0;
        end else if (phase_r + 3'h1 >= half_per) begin
            phase_r       <= 3'h0;
            clock_out_pin <= ~clock_out_pin;
        end else begin
            phase_r       <= phase_r + 3'h1;
        end
    end

    chk_clkout_eighth: assert property (@(posedge clock) disable iff (rst)
        $rose(clock_out_pin) && clock_pin_divider_r == 2'h0 && rate_k == 4'h1
            && !hold ##1 (!hold && clock_pin_divider_r == 2'h0 && rate_k == 4'h1)[*3]
        |-> $past(clock_out_pin, 3) && clock_out_pin ##1 !clock_out_pin)
        else $error("clock out not reference/8 with divider field zero");

endmodule : cprs_clkout_div
`default_nettype wire

// ### rtl/cprs_sequencer.sv
// clock, pll and reset sequencer top
// Notes on behaviour
// - ratio write starts lock phase at half rate
// - lock lasts 131072 cycles, then multiplied rate
// - core multiplier equals ratio value divided by two, one half for ratio zero
// - power-up core clock is half the reference
// - divider field resets to zero, core/4
// - watchdog reset pulse lasts 512 reference cycles
// - bus drives valid 32 cycles after release
`timescale 1ns/1ps
`default_nettype none
`include "cprs_map.svh"

module cprs_sequencer #(
    parameter int LOCK_CYCLES = `CPRS_PLL_LOCK_CYC
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       external_reset_n,
    input  wire logic                       wd_trigger,
    input  wire logic                       pll_ratio_wr,
    input  wire logic [`CPRS_RATIO_W-1:0]   pll_ratio_wdata,
    input  wire logic                       clkout_cfg_wr,
    input  wire logic [`CPRS_DIV_W-1:0]     clkout_cfg_wdata,
    output var  cprs_pkg::cprs_core_cfg_s   core_cfg_r,
    output var  logic                       sys_reset_r,
    output var  logic                       bus_valid_r,
    output var  logic                       clock_out_pin
);

    logic                           ext_meta_r;
    logic                           ext_sync_r;
    logic                           wd_active_r;
    logic [`CPRS_WD_CNT_W-1:0]      wd_cnt_r;
    logic                           sys_hold;
    logic [`CPRS_LOCK_CNT_W-1:0]    lock_cnt_r;
    cprs_pkg::cprs_core_cfg_s       core_cfg_nxt;
    logic                           ratio_wr;
    cprs_pkg::cprs_seq_e            seq_r;
    logic [`CPRS_BUS_CNT_W-1:0]     bus_cnt_r;
    logic [17:0]                    lock_age_r;
    logic [9:0]                     wd_age_r;

    // reset pin is asynchronous to the reference; low while in reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
        end else begin
            ext_meta_r <= external_reset_n;
            ext_sync_r <= ext_meta_r;
        end
    end

    // retrigger during the pulse is ignored so the width stays fixed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wd_active_r <= 1'b0;
            wd_cnt_r    <= '0;
        end else if (!wd_active_r) begin
            wd_active_r <= wd_trigger;
            wd_cnt_r    <= '0;
        end else if (wd_cnt_r == `CPRS_WD_CNT_W'(`CPRS_WD_PULSE_CYC - 1)) begin
            wd_active_r <= 1'b0;
        end else begin
            wd_cnt_r    <= wd_cnt_r + `CPRS_WD_CNT_W'(1);
        end
    end

    assign sys_hold = !ext_sync_r || wd_active_r;
    assign ratio_wr = pll_ratio_wr && !sys_hold;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_reset_r <= 1'b1;
        end else begin
            sys_reset_r <= sys_hold;
        end
    end

    always_comb begin
        core_cfg_nxt = core_cfg_r;
        if (sys_hold) begin
            core_cfg_nxt.locking = 1'b0;
            core_cfg_nxt.ratio   = `CPRS_RATIO_RST;
        end else if (ratio_wr) begin
            core_cfg_nxt.locking = 1'b1;
            core_cfg_nxt.ratio   = pll_ratio_wdata;
        end else if (core_cfg_r.locking && lock_cnt_r == '0) begin
            core_cfg_nxt.locking = 1'b0;
        end
        // zero ratio keeps the pll bypassed at half rate
        core_cfg_nxt.half_rate = core_cfg_nxt.locking || core_cfg_nxt.ratio == '0;
        core_cfg_nxt.rate_k    = core_cfg_nxt.half_rate ? `CPRS_RATIO_W'(1)
                                                        : core_cfg_nxt.ratio;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            core_cfg_r <= '{half_rate: 1'b1, locking: 1'b0,
                            ratio: `CPRS_RATIO_RST, rate_k: `CPRS_RATIO_W'(1)};
        end else begin
            core_cfg_r <= core_cfg_nxt;
        end
    end

    // a write during lock restarts the full lock time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_cnt_r <= '0;
        end else if (sys_hold) begin
            lock_cnt_r <= '0;
        end else if (ratio_wr) begin
            lock_cnt_r <= `CPRS_LOCK_CNT_W'(LOCK_CYCLES - 1);
        end else if (lock_cnt_r != '0) begin
            lock_cnt_r <= lock_cnt_r - `CPRS_LOCK_CNT_W'(1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seq_r       <= cprs_pkg::CPRS_SEQ_HOLD;
            bus_cnt_r   <= '0;
            bus_valid_r <= 1'b0;
        end else if (sys_hold) begin
            seq_r       <= cprs_pkg::CPRS_SEQ_HOLD;
            bus_cnt_r   <= '0;
            bus_valid_r <= 1'b0;
        end else begin
            case (seq_r)
                cprs_pkg::CPRS_SEQ_HOLD: begin
                    seq_r     <= cprs_pkg::CPRS_SEQ_WAIT;
                    bus_cnt_r <= `CPRS_BUS_CNT_W'(1);
                end
                cprs_pkg::CPRS_SEQ_WAIT: begin
                    if (bus_cnt_r == `CPRS_BUS_CNT_W'(`CPRS_BUS_DELAY_CYC - 1)) begin
                        seq_r       <= cprs_pkg::CPRS_SEQ_RUN;
                        bus_valid_r <= 1'b1;
                    end else begin
                        bus_cnt_r <= bus_cnt_r + `CPRS_BUS_CNT_W'(1);
                    end
                end
                cprs_pkg::CPRS_SEQ_RUN: begin
                    bus_valid_r <= 1'b1;
                end
                default: begin
                    seq_r <= cprs_pkg::CPRS_SEQ_HOLD;
                end
            endcase
        end
    end

    cprs_clkout_div u_clkout (
        .clock         (clock),
        .rst           (rst),
        .hold          (sys_hold),
        .div_wr        (clkout_cfg_wr && !sys_hold),
        .div_wdata     (clkout_cfg_wdata),
        .rate_k        (core_cfg_r.rate_k),
        .clock_out_pin (clock_out_pin)
    );

    // helper counters read only by the checks below
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_age_r <= '0;
        end else if (!core_cfg_nxt.locking) begin
            lock_age_r <= '0;
        end else if (ratio_wr) begin
            lock_age_r <= 18'h1;
        end else begin
            lock_age_r <= lock_age_r + 18'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wd_age_r <= '0;
        end else if (wd_active_r) begin
            wd_age_r <= wd_age_r + 10'h1;
        end else begin
            wd_age_r <= '0;
        end
    end

    chk_lock_start: assert property (@(posedge clock) disable iff (rst)
        ratio_wr |=> core_cfg_r.locking && core_cfg_r.half_rate
            && core_cfg_r.rate_k == 4'h1 && core_cfg_r.ratio == $past(pll_ratio_wdata))
        else $error("ratio write did not start half rate lock");

    chk_lock_length: assert property (@(posedge clock) disable iff (rst)
        $fell(core_cfg_r.locking) && !$past(sys_hold) |-> $past(lock_age_r) == LOCK_CYCLES)
        else $error("lock phase length wrong");

    chk_lock_end: assert property (@(posedge clock) disable iff (rst)
        $fell(core_cfg_r.locking) && !$past(sys_hold) && core_cfg_r.ratio != 4'h0
        |-> !core_cfg_r.half_rate && core_cfg_r.rate_k == core_cfg_r.ratio)
        else $error("core clock did not switch after lock");

    chk_rate_mult: assert property (@(posedge clock) disable iff (rst)
        !core_cfg_r.half_rate |-> core_cfg_r.rate_k == core_cfg_r.ratio
            && !core_cfg_r.locking && core_cfg_r.ratio != 4'h0)
        else $error("core rate not ratio over two");

    chk_power_half: assert property (@(posedge clock) disable iff (rst)
        core_cfg_r.ratio == 4'h0 |-> core_cfg_r.half_rate && core_cfg_r.rate_k == 4'h1)
        else $error("unprogrammed core clock not half rate");

    chk_wd_width: assert property (@(posedge clock) disable iff (rst)
        $fell(wd_active_r) |-> wd_age_r == 10'h200)
        else $error("watchdog reset pulse width wrong");

    chk_bus_delay: assert property (@(posedge clock) disable iff (rst)
        $rose(bus_valid_r) |-> $past(sys_hold, 33) && !$past(sys_hold, 32)
            && !$past(sys_hold, 1))
        else $error("bus valid not 32 cycles after release");

    chk_hold_reset: assert property (@(posedge clock) disable iff (rst)
        sys_hold |=> !bus_valid_r && sys_reset_r && !core_cfg_r.locking
            && core_cfg_r.ratio == 4'h0 && !clock_out_pin)
        else $error("logic not held in reset");

endmodule : cprs_sequencer
`default_nettype wire

// ### test/cprs_supervisor.sv
// model of the external reset supervisor
`timescale 1ns/1ps
`default_nettype none

module cprs_supervisor #(
    parameter int         LOW_CYCLES = 8,
    parameter logic [1:0] BOOT_VAL   = 2'h1,
    parameter int         BOOT_HOLD  = 200
) (
    input  wire logic       clock,
    input  wire logic       warm_req,
    output var  logic       external_reset_n,
    output var  logic [1:0] boot_pins
);
    int cnt = 0;
    int rel_cnt = 0;

    initial external_reset_n = 1'b0;

    // low is counted on a running clock only, so a stalled clock never releases it
    always @(posedge clock) begin
        if (warm_req) begin
            cnt <= 0;
            external_reset_n <= 1'b0;
        end else if (cnt < LOW_CYCLES - 1) begin
            cnt <= cnt + 1;
        end else begin
            external_reset_n <= 1'b1;
        end
    end

    // straps stand still while reset is low and for the hold time after release
    always @(posedge clock) begin
        if (!external_reset_n) begin
            rel_cnt   <= 0;
            boot_pins <= BOOT_VAL;
        end else if (rel_cnt < BOOT_HOLD) begin
            rel_cnt   <= rel_cnt + 1;
        end else begin
            boot_pins <= ~boot_pins;
        end
    end
endmodule : cprs_supervisor

`default_nettype wire

// ### test/cprs_sequencer_tb.sv
// self-checking bench of the clock, pll and reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cprs_map.svh"

module cprs_sequencer_tb;
    localparam int LOCK = 16;
    localparam logic [10:0] CFG_RST = {1'b1, 1'b0, 4'h0, 4'h1};
    localparam logic [1:0]  BOOT = 2'h2;
    logic [1:0]               boot_pins;
    logic                     clock = 1'b0;
    logic                     rst = 1'b1;
    logic                     warm_req = 1'b0;
    logic                     wd_trigger = 1'b0;
    logic                     pll_ratio_wr = 1'b0;
    logic [3:0]               pll_ratio_wdata = 4'h0;
    logic                     clkout_cfg_wr = 1'b0;
    logic [1:0]               clkout_cfg_wdata = 2'h0;
    logic                     external_reset_n;
    cprs_pkg::cprs_core_cfg_s core_cfg_r;
    logic                     sys_reset_r;
    logic                     bus_valid_r;
    logic                     clock_out_pin;
    int                       error_cnt = 0;
    int                       checked = 0;
    int                       q_lock[$];
    int                       q_rst[$];
    int                       q_bus[$];
    logic [10:0]              q_cfg[$];
    int                       lcnt = 0, rcnt = 0, bcnt = 0, exp, n, d;
    logic                     p_lock = 1'b0, p_rst = 1'b0, p_bus = 1'b0;
    logic [3:0]               r2;

    initial forever #(`CPRS_CLK_NS / 2) clock = ~clock;

    cprs_supervisor #(.LOW_CYCLES(8), .BOOT_VAL(BOOT), .BOOT_HOLD(200)) cprs_supervisor_i (
        .clock(clock), .warm_req(warm_req), .external_reset_n(external_reset_n),
        .boot_pins(boot_pins));

    cprs_sequencer #(.LOCK_CYCLES(LOCK)) cprs_sequencer_i (
        .clock(clock), .rst(rst), .external_reset_n(external_reset_n),
        .wd_trigger(wd_trigger), .pll_ratio_wr(pll_ratio_wr),
        .pll_ratio_wdata(pll_ratio_wdata), .clkout_cfg_wr(clkout_cfg_wr),
        .clkout_cfg_wdata(clkout_cfg_wdata), .core_cfg_r(core_cfg_r),
        .sys_reset_r(sys_reset_r), .bus_valid_r(bus_valid_r), .clock_out_pin(clock_out_pin));

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            error_cnt++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, expv);
        end
    endtask : check

    task automatic end_sim();
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick

    task automatic wr_ratio(input logic [3:0] v);
        pll_ratio_wdata = v;
        pll_ratio_wr = 1'b1;
        tick(1);
        pll_ratio_wr = 1'b0;
    endtask : wr_ratio

    task automatic wr_div(input logic [1:0] v);
        clkout_cfg_wdata = v;
        clkout_cfg_wr = 1'b1;
        tick(1);
        clkout_cfg_wr = 1'b0;
        tick(12);
    endtask : wr_div

    task automatic half_per(output int h);
        h = 0;
        for (int i = 0; i < 20 && clock_out_pin !== 1'b0; i++) tick(1);
        for (int i = 0; i < 20 && clock_out_pin !== 1'b1; i++) tick(1);
        while (clock_out_pin === 1'b1 && h < 20) begin
            h++;
            tick(1);
        end
    endtask : half_per

    task automatic wait_bus();
        for (int i = 0; i < 700 && bus_valid_r !== 1'b1; i++) tick(1);
    endtask : wait_bus

    // result watcher: each event takes the oldest note of its kind
    always @(posedge clock) begin
        #2;
        bcnt = sys_reset_r ? 0 : bcnt + 1;
        if (p_lock && !core_cfg_r.locking) begin
            check(lcnt, q_lock.size() > 0 ? q_lock.pop_front() : -2);
            check(core_cfg_r, q_cfg.size() > 0 ? q_cfg.pop_front() : 11'hx);
        end
        if (p_rst && !sys_reset_r) begin
            exp = q_rst.size() > 0 ? q_rst.pop_front() : -2;
            if (exp != -1) check(rcnt, exp);
            else check(boot_pins, BOOT);
        end
        if (!p_bus && bus_valid_r) check(bcnt, q_bus.size() > 0 ? q_bus.pop_front() : -2);
        lcnt = core_cfg_r.locking ? lcnt + 1 : 0;
        rcnt = sys_reset_r ? rcnt + 1 : 0;
        p_lock = core_cfg_r.locking;
        p_rst = sys_reset_r;
        p_bus = bus_valid_r;
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h0607060b));
        q_rst.push_back(-1);
        q_bus.push_back(`CPRS_BUS_DELAY_CYC);
        tick(2);
        rst = 1'b0;
        wr_ratio(4'($urandom_range(1, 15)));
        wait_bus();
        check(core_cfg_r, CFG_RST);
        for (int c = 0; c < 4; c++) begin
            wr_div(2'(c));
            half_per(n);
            check(n, c == 0 ? 4 : (c == 1 ? 2 : 1));
        end
        wr_div(2'h0);
        half_per(n);
        check(n, 4);
        q_lock.push_back(LOCK);
        q_cfg.push_back({1'b0, 1'b0, 4'h4, 4'h4});
        wr_ratio(4'h4);
        check(core_cfg_r, {1'b1, 1'b1, 4'h4, 4'h1});
        tick(LOCK + 2);
        half_per(n);
        check(n, 1);
        r2 = 4'(2 << $urandom_range(0, 2));
        d = $urandom_range(2, LOCK - 2);
        q_lock.push_back(d + LOCK);
        q_cfg.push_back({1'b0, 1'b0, r2, r2});
        wr_ratio(4'h8);
        tick(d - 1);
        wr_ratio(r2);
        check(core_cfg_r.half_rate, 1'b1);
        tick(LOCK + 2);
        wr_div(2'h1);
        q_rst.push_back(`CPRS_WD_PULSE_CYC);
        q_bus.push_back(`CPRS_BUS_DELAY_CYC);
        wd_trigger = 1'b1;
        tick(1);
        wd_trigger = 1'b0;
        tick(100);
        check(bus_valid_r, 1'b0);
        wd_trigger = 1'b1;
        tick(1);
        wd_trigger = 1'b0;
        wait_bus();
        check(core_cfg_r, CFG_RST);
        half_per(n);
        check(n, 4);
        q_lock.push_back(LOCK);
        q_cfg.push_back(CFG_RST);
        wr_ratio(4'h0);
        check(core_cfg_r.locking, 1'b1);
        tick(LOCK + 2);
        half_per(n);
        check(n, 4);
        wr_div(2'h1);
        q_rst.push_back(-1);
        q_bus.push_back(`CPRS_BUS_DELAY_CYC);
        warm_req = 1'b1;
        tick(1);
        warm_req = 1'b0;
        tick(4);
        wr_ratio(4'h6);
        wait_bus();
        check(core_cfg_r, CFG_RST);
        half_per(n);
        check(n, 4);
        tick(10);
        check(q_lock.size() + q_rst.size() + q_bus.size(), 0);
        end_sim();
    end
endmodule : cprs_sequencer_tb

`default_nettype wire
